// [shared/coherency_pkg.sv]
package coherency_pkg;

  localparam int ADDR_W      = 32;
  localparam int LINE_COUNT  = 16;
  localparam int INDEX_W     = 4;
  localparam int OFFSET_W    = 6;
  localparam int TAG_W       = ADDR_W - INDEX_W - OFFSET_W;
  localparam int INDEX_LSB   = OFFSET_W;
  localparam int TAG_LSB     = OFFSET_W + INDEX_W;
  localparam int QWORD_LSB   = 3;
  localparam logic [3:0] QWORD_LAST = 4'h7;

  typedef enum logic [2:0] {
    LINE_I = 3'b000,
    LINE_S = 3'b001,
    LINE_E = 3'b010,
    LINE_O = 3'b011,
    LINE_M = 3'b100
  } line_state_t;

  typedef enum logic {
    ST_LOOK = 1'b0,
    ST_MISS = 1'b1
  } fsm_state_t;

  // load or store from the core; held until cpu_ack
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              atomic_exchange_op;
    logic              bus_lock;
    logic [2:0]        size_m1;
    logic [ADDR_W-1:0] addr;
  } cpu_req_t;

  // probe from another master; held until probe_ack
  typedef struct packed {
    logic              valid;
    logic              write;
    logic              caching;
    logic [ADDR_W-1:0] addr;
  } probe_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic supply;
    logic retained;
  } probe_rsp_t;

  // own miss: probe the other masters and read memory
  typedef struct packed {
    logic              valid;
    logic              write_probe;
    logic              victim_dirty;
    logic [ADDR_W-1:0] addr;
  } miss_req_t;

  typedef struct packed {
    logic valid;
    logic shared;
  } fill_rsp_t;

endpackage

// [logic/moesi_cache_coherency.sv]
`timescale 1ns/10ps
module moesi_cache_coherency
  import coherency_pkg::*;
(
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // core side
  input  wire coherency_pkg::cpu_req_t  cpu_req,
  output      logic                     cpu_ack,
  // probes from other masters
  input  wire coherency_pkg::probe_req_t probe_in,
  output      coherency_pkg::probe_rsp_t probe_ack,
  output      logic                     probe_stall,
  // own misses
  output      coherency_pkg::miss_req_t miss_out,
  input  wire coherency_pkg::fill_rsp_t fill_in
);
  import coherency_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [INDEX_W-1:0] index_of(
    input logic [ADDR_W-1:0] a);
    index_of = a[TAG_LSB-1:INDEX_LSB];
  endfunction

  function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
    tag_of = a[ADDR_W-1:TAG_LSB];
  endfunction

  function automatic logic holds_newest(input line_state_t s);
    holds_newest = (s == LINE_M) || (s == LINE_O);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  line_state_t      state_reg [LINE_COUNT];
  line_state_t      state_next[LINE_COUNT];
  logic [TAG_W-1:0] tag_reg   [LINE_COUNT];
  logic [TAG_W-1:0] tag_next  [LINE_COUNT];

  fsm_state_t fsm_reg;
  fsm_state_t fsm_next;
  logic       phase_reg;
  logic       phase_next;
  logic       lock_reg;
  logic       lock_next;
  logic       cpu_ack_reg;
  logic       cpu_ack_next;
  probe_rsp_t probe_ack_reg;
  probe_rsp_t probe_ack_next;
  miss_req_t  miss_reg;
  miss_req_t  miss_next;

  logic [ADDR_W-1:0]  second_addr;
  logic [ADDR_W-1:0]  cur_addr;
  logic [INDEX_W-1:0] cur_idx;
  logic [INDEX_W-1:0] probe_idx;
  line_state_t        cur_state;
  line_state_t        p_state;
  logic               c_hit;
  logic               p_hit;
  logic               crosses;
  logic               locked;
  logic               take_probe;
  logic               cpu_go;
  logic               fill_go;

  ////////////////////////////////////////////////////////////////////////////
  // lookup
  assign second_addr = {cpu_req.addr[ADDR_W-1:QWORD_LSB]
                        + {{(ADDR_W-QWORD_LSB-1){1'b0}}, 1'b1},
                        {QWORD_LSB{1'b0}}};
  assign cur_addr    = phase_reg ? second_addr : cpu_req.addr;
  assign cur_idx     = index_of(cur_addr);
  assign probe_idx   = index_of(probe_in.addr);
  assign cur_state   = state_reg[cur_idx];
  assign p_state     = state_reg[probe_idx];
  assign c_hit       = (cur_state != LINE_I)
                       && (tag_reg[cur_idx] == tag_of(cur_addr));
  assign p_hit       = (p_state != LINE_I)
                       && (tag_reg[probe_idx] == tag_of(probe_in.addr));
  // split only when the bytes leave one aligned quadword
  assign crosses     = ({1'b0, cpu_req.addr[QWORD_LSB-1:0]}
                        + {1'b0, cpu_req.size_m1}) > QWORD_LAST;
  assign locked      = cpu_req.atomic_exchange_op || cpu_req.bus_lock;
  // probes wait while a locked split access is between its halves
  assign take_probe  = probe_in.valid && !probe_ack_reg.valid
                       && !lock_reg;
  assign cpu_go      = (fsm_reg == ST_LOOK) && cpu_req.valid
                       && !cpu_ack_reg && !take_probe;
  assign fill_go     = (fsm_reg == ST_MISS) && fill_in.valid;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next     = state_reg;
    tag_next       = tag_reg;
    fsm_next       = fsm_reg;
    phase_next     = phase_reg;
    lock_next      = lock_reg;
    cpu_ack_next   = 1'b0;
    probe_ack_next = '0;
    miss_next      = miss_reg;

    if (take_probe) begin
      probe_ack_next.valid  = 1'b1;
      probe_ack_next.hit    = p_hit;
      probe_ack_next.supply = p_hit && holds_newest(p_state);
      if (p_hit) begin
        if (probe_in.write) begin
          state_next[probe_idx] = LINE_I;
        end else if (probe_in.caching) begin
          if (p_state == LINE_M) begin
            state_next[probe_idx] = LINE_O;
          end else if (p_state == LINE_E) begin
            state_next[probe_idx] = LINE_S;
          end
        end
        // non-caching read probe keeps the line as it is
      end
      probe_ack_next.retained = p_hit && !probe_in.write;
    end

    case (fsm_reg)
      ST_LOOK: begin
        if (cpu_go) begin
          if (c_hit) begin
            // reads keep the state; writes always end modified
            if (cpu_req.write) begin
              state_next[cur_idx] = LINE_M;
            end
            if (crosses && !phase_reg) begin
              phase_next = 1'b1;
              lock_next  = locked;
            end else begin
              cpu_ack_next = 1'b1;
              phase_next   = 1'b0;
              lock_next    = 1'b0;
            end
          end else begin
            miss_next.valid        = 1'b1;
            miss_next.write_probe  = cpu_req.write;
            miss_next.addr         = cur_addr;
            miss_next.victim_dirty = (cur_state != LINE_I)
                                     && holds_newest(cur_state);
            fsm_next               = ST_MISS;
          end
        end
      end
      ST_MISS: begin
        if (fill_go) begin
          // fill never owns; a write retries as a hit on the filled shared or exclusive line
          tag_next[cur_idx]   = tag_of(cur_addr);
          state_next[cur_idx] = fill_in.shared ? LINE_S : LINE_E;
          miss_next           = '0;
          fsm_next            = ST_LOOK;
        end
      end
      default: begin
        fsm_next = ST_LOOK;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LINE_COUNT; i++) begin
        state_reg[i] <= LINE_I;
        tag_reg[i]   <= '0;
      end
      fsm_reg       <= ST_LOOK;
      phase_reg     <= 1'b0;
      lock_reg      <= 1'b0;
      cpu_ack_reg   <= 1'b0;
      probe_ack_reg <= '0;
      miss_reg      <= '0;
    end else begin
      for (int i = 0; i < LINE_COUNT; i++) begin
        state_reg[i] <= state_next[i];
        tag_reg[i]   <= tag_next[i];
      end
      fsm_reg       <= fsm_next;
      phase_reg     <= phase_next;
      lock_reg      <= lock_next;
      cpu_ack_reg   <= cpu_ack_next;
      probe_ack_reg <= probe_ack_next;
      miss_reg      <= miss_next;
    end
  end

  assign cpu_ack     = cpu_ack_reg;
  assign probe_ack   = probe_ack_reg;
  assign probe_stall = lock_reg;
  assign miss_out    = miss_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_read_hit;
    cpu_go && c_hit && !cpu_req.write;
  endsequence

  sequence s_write_hit;
    cpu_go && c_hit && cpu_req.write;
  endsequence

  sequence s_locked_first;
    cpu_go && c_hit && crosses && !phase_reg && locked;
  endsequence

  sequence s_probe_hit;
    take_probe && p_hit;
  endsequence

  a_read_hit_keep: assert property (
    @(posedge clock) disable iff (rst)
    s_read_hit and (!(take_probe && probe_idx == cur_idx))
    |=> state_reg[$past(cur_idx)] == $past(cur_state))
    else $error("read hit changed line state");

  a_write_hit_mod: assert property (
    @(posedge clock) disable iff (rst)
    s_write_hit |=> state_reg[$past(cur_idx)] == LINE_M)
    else $error("write hit did not leave line modified");

  a_probe_write_inv: assert property (
    @(posedge clock) disable iff (rst)
    s_probe_hit and (probe_in.write && !fill_go
      && !(cpu_go && cur_idx == probe_idx))
    |=> state_reg[$past(probe_idx)] == LINE_I && probe_ack.valid)
    else $error("write probe did not invalidate line");

  a_probe_supply: assert property (
    @(posedge clock) disable iff (rst)
    take_probe |=> probe_ack.valid
      && probe_ack.supply == ($past(p_hit) && holds_newest($past(p_state))))
    else $error("probe supply flag wrong");

  a_read_probe_own: assert property (
    @(posedge clock) disable iff (rst)
    s_probe_hit and (!probe_in.write && probe_in.caching
      && p_state == LINE_M && !cpu_go && !fill_go)
    |=> state_reg[$past(probe_idx)] == LINE_O)
    else $error("caching read probe on modified did not give owned");

  a_noncache_keep: assert property (
    @(posedge clock) disable iff (rst)
    s_probe_hit and (!probe_in.write && !probe_in.caching && !cpu_go
      && !fill_go)
    |=> state_reg[$past(probe_idx)] == $past(p_state))
    else $error("non-caching probe changed line state");

  a_fill_state: assert property (
    @(posedge clock) disable iff (rst)
    fill_go |=> (state_reg[$past(cur_idx)] == LINE_S
                 || state_reg[$past(cur_idx)] == LINE_E)
                && !miss_out.valid && fsm_reg == ST_LOOK)
    else $error("fill gave wrong line state");

  a_miss_issue: assert property (
    @(posedge clock) disable iff (rst)
    cpu_go && !c_hit |=> miss_out.valid
      && miss_out.write_probe == $past(cpu_req.write)
      && miss_out.addr == $past(cur_addr))
    else $error("miss not issued");

  a_lock_stall: assert property (
    @(posedge clock) disable iff (rst)
    s_locked_first |=> probe_stall && phase_reg && !cpu_ack
      ##1 (probe_stall || cpu_ack))
    else $error("locked split access not held atomic");

  a_stall_no_probe: assert property (
    @(posedge clock) disable iff (rst)
    probe_stall |-> !take_probe ##1 !probe_ack.valid || probe_stall)
    else $error("probe taken during locked access");

  a_aligned_one: assert property (
    @(posedge clock) disable iff (rst)
    cpu_go && c_hit && !crosses |=> cpu_ack && !phase_reg)
    else $error("aligned hit not completed in one step");

endmodule

// [verification/fill_responder.sv]
`timescale 1ns/10ps
module fill_responder
  import coherency_pkg::*;
(
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // miss traffic and fill answer
  input  wire coherency_pkg::miss_req_t miss_out,
  input  wire logic                     shared_sel,
  input  wire logic [3:0]               fill_delay,
  output      coherency_pkg::fill_rsp_t fill_in
);
  import coherency_pkg::*;
  typedef enum logic [1:0] {F_IDLE, F_WAIT, F_DONE} fill_state_t;
  fill_state_t state_reg;
  fill_state_t state_next;
  logic [3:0]  count_reg;
  logic [3:0]  count_next;
  logic        fire_reg;
  logic        fire_next;
  ////////////////////////////////////////////////////////////////
  // memory answers every miss after a set delay
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    fire_next  = 1'b0;
    case (state_reg)
      F_IDLE: if (miss_out.valid) begin
        state_next = F_WAIT;
        count_next = fill_delay;
      end
      F_WAIT: if (count_reg == 4'h0) begin
        fire_next  = 1'b1;
        state_next = F_DONE;
      end else begin
        count_next = count_reg - 4'h1;
      end
      default: if (!miss_out.valid) begin
        state_next = F_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= F_IDLE;
      count_reg <= 4'h0;
      fire_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      fire_reg  <= fire_next;
    end
  end
  ////////////////////////////////////////////////////////////////
  // shared only says whether another cache kept a copy
  assign fill_in = {fire_reg, fire_reg ? shared_sel : ~shared_sel};
endmodule

// [verification/moesi_cache_coherency_bench.sv]
`timescale 1ns/10ps
module moesi_cache_coherency_bench;
  import coherency_pkg::*;
  logic       clock;
  logic       rst;
  cpu_req_t   cpu_req;
  logic       cpu_ack;
  probe_req_t probe_in;
  probe_rsp_t probe_ack;
  logic       probe_stall;
  miss_req_t  miss_out;
  fill_rsp_t  fill_in;
  logic       shared_sel;
  logic [3:0] fill_delay;
  int         fails;
  int         checked;
  int         cyc;
  logic       m_seen;
  miss_req_t  m_cap;
  probe_rsp_t rsp;
  time        t_cpu;
  time        t_prb;
  moesi_cache_coherency uut (.clock(clock), .rst(rst), .cpu_req(cpu_req),
    .cpu_ack(cpu_ack), .probe_in(probe_in), .probe_ack(probe_ack),
    .probe_stall(probe_stall), .miss_out(miss_out), .fill_in(fill_in));
  fill_responder mem (.clock(clock), .rst(rst), .miss_out(miss_out),
    .shared_sel(shared_sel), .fill_delay(fill_delay), .fill_in(fill_in));
  always #20 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cpu_op(input logic w, x, l, input logic [2:0] sz,
                        input logic [31:0] a);
    m_seen = 1'b0;
    m_cap  = '0;
    cpu_req.valid = 1'b1;
    cpu_req.write = w;
    cpu_req.atomic_exchange_op = x;
    cpu_req.bus_lock = l;
    cpu_req.size_m1 = sz;
    cpu_req.addr = a;
    for (cyc = 1; cyc <= 60; cyc++) begin
      @(posedge clock);
      #1;
      if (miss_out.valid && !m_seen) begin
        m_seen = 1'b1;
        m_cap  = miss_out;
      end
      if (cpu_ack === 1'b1) break;
    end
    t_cpu = $time;
    if (cyc > 60) begin
      fails++;
      report_and_stop();
    end
    cpu_req = '0;
    @(posedge clock);
    #1;
  endtask
  task automatic probe_op(input logic w, c, input logic [31:0] a);
    int n;
    probe_in.valid = 1'b1;
    probe_in.write = w;
    probe_in.caching = c;
    probe_in.addr = a;
    for (n = 1; n <= 60; n++) begin
      @(posedge clock);
      #1;
      if (probe_ack.valid === 1'b1) break;
    end
    rsp   = probe_ack;
    t_prb = $time;
    if (n > 60) begin
      fails++;
      report_and_stop();
    end
    probe_in = '0;
    @(posedge clock);
    #1;
  endtask
  // probe answer as {valid, hit, supply, retained}
  task automatic probe_chk(input logic w, c, input logic [31:0] a,
                           input logic [3:0] exp);
    probe_op(w, c, a);
    check(rsp, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic s_load_miss();
    shared_sel = 1'b0;
    cpu_op(1'b0, 1'b0, 1'b0, 3'h7, 32'h0000_0040);
    check({m_seen, m_cap.write_probe, m_cap.victim_dirty}, 3'h4);
    check(m_cap.addr, 32'h0000_0040);
    probe_chk(1'b1, 1'b0, 32'h0000_0040, 4'hC);
    probe_chk(1'b0, 1'b1, 32'h0000_0040, 4'h8);
  endtask
  task automatic s_store_path();
    fill_delay = 4'h0;
    cpu_op(1'b1, 1'b0, 1'b0, 3'h3, 32'h0000_0048);
    check({m_seen, m_cap.write_probe}, 2'h3);
    cpu_op(1'b1, 1'b0, 1'b0, 3'h3, 32'h0000_0048);
    check({m_seen, 5'(cyc)}, 6'h01);
    probe_chk(1'b0, 1'b0, 32'h0000_0040, 4'hF);
    probe_chk(1'b0, 1'b1, 32'h0000_0040, 4'hF);
    probe_chk(1'b0, 1'b1, 32'h0000_0040, 4'hF);
    cpu_op(1'b0, 1'b0, 1'b0, 3'h0, 32'h0000_0041);
    check({m_seen, 5'(cyc)}, 6'h01);
    probe_chk(1'b1, 1'b0, 32'h0000_0040, 4'hE);
    cpu_op(1'b1, 1'b0, 1'b0, 3'h0, 32'h0000_0040);
    cpu_op(1'b0, 1'b0, 1'b0, 3'h0, 32'h0000_0440);
    check({m_seen, m_cap.victim_dirty}, 2'h3);
    fill_delay = 4'h3;
  endtask
  task automatic s_shared_fill();
    shared_sel = 1'b1;
    cpu_op(1'b0, 1'b0, 1'b0, 3'h7, 32'h0000_0080);
    probe_chk(1'b0, 1'b1, 32'h0000_0080, 4'hD);
    cpu_op(1'b1, 1'b0, 1'b0, 3'h7, 32'h0000_0080);
    probe_chk(1'b0, 1'b1, 32'h0000_0080, 4'hF);
    cpu_op(1'b0, 1'b0, 1'b0, 3'h7, 32'h0000_0080);
    probe_chk(1'b0, 1'b1, 32'h0000_0080, 4'hF);
  endtask
  task automatic s_atomicity();
    int k;
    cpu_op(1'b0, 1'b0, 1'b0, 3'h7, 32'h0000_0088);
    check(5'(cyc), 5'h01);
    cpu_op(1'b0, 1'b0, 1'b0, 3'h3, 32'h0000_0082);
    check(5'(cyc), 5'h01);
    cpu_op(1'b0, 1'b0, 1'b0, 3'h3, 32'h0000_0086);
    check(5'(cyc), 5'h02);
    for (k = 0; k < 3; k++) begin
      fork
        cpu_op(1'b0, k == 0, k == 1, 3'h3, 32'h0000_0086);
        begin
          @(posedge clock);
          #1;
          check(probe_stall, k != 2);
          probe_op(1'b0, 1'b0, 32'h0000_0080);
        end
      join
      check(t_prb > t_cpu, k != 2);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    cpu_req = '0;
    probe_in = '0;
    shared_sel = 1'b0;
    fill_delay = 4'h3;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge clock);
    #1;
    rst = 1'b0;
    @(posedge clock);
    #1;
    s_load_miss();
    s_store_path();
    s_shared_fill();
    s_atomicity();
    report_and_stop();
  end
endmodule
